/* File: e1_alarm_gen.sv */
/*
  E1 alarm and AIS generator for one framer channel, with Wishbone registers.
  Assumes defect inputs and the transmit bit stream come from framer logic
  on clk_i; tx_stb_i marks one E1 bit time, tx_sync_i its multiframe start.
*/
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module e1_alarm_gen #(
  parameter int INTEG_CYCLES   = 100,
  parameter int DEINTEG_CYCLES = 100,
  parameter int CNT_W          = 16
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           ce_i,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [e1_alarm_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [e1_alarm_pkg::SEL_W-1:0] wb_sel_i,
  input  wire logic [e1_alarm_pkg::DAT_W-1:0] wb_dat_i,
  output logic                                wb_ack_o,
  output logic      [e1_alarm_pkg::DAT_W-1:0] wb_dat_o,
  input  wire logic                           rx_los_i,
  input  wire logic                           rx_lof_i,
  input  wire logic                           rx_ais_i,
  input  wire logic                           rx_cas_lomf_i,
  input  wire logic                           rx_sig_ones_i,
  input  wire logic                           rx_sig_corrupt_i,
  input  wire logic                           rx_bpv_i,
  input  wire logic                           rx_bit_err_i,
  input  wire logic                           tx_stb_i,
  input  wire logic                           tx_sync_i,
  input  wire logic                           tx_bit_i,
  output logic                                tx_line_o,
  output logic                                tx_vld_o,
  output logic                                red_alarm_o,
  output logic                                irq_o
);
  import e1_alarm_pkg::*;
  localparam logic [CNT_W-1:0] INTEG_LAST   = CNT_W'(INTEG_CYCLES - 1);
  localparam logic [CNT_W-1:0] DEINTEG_LAST = CNT_W'(DEINTEG_CYCLES - 1);
  if (INTEG_CYCLES < 1 || DEINTEG_CYCLES < 1 || CNT_W < 1 || CNT_W > 30 ||
      INTEG_CYCLES > (1 << CNT_W) || DEINTEG_CYCLES > (1 << CNT_W)) begin : g_bad_param
    $error("Integration counts do not fit the counter width");
  end
  function automatic logic reg_hit(input logic [ADR_W-1:0] adr,
                                   input logic [ADR_W-1:0] ofs);
    return adr[ADR_W-1:2] == ofs[ADR_W-1:2];
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Defect integration
  logic [NUM_DEF-1:0] defect;
  logic [NUM_DEF-1:0] alarm_ff;
  logic [NUM_DEF-1:0] nxt_alarm;
  logic [CNT_W-1:0]   cnt_ff  [NUM_DEF];
  logic [CNT_W-1:0]   nxt_cnt [NUM_DEF];

  always_comb begin
    // Line errors have no path into this vector
    defect            = '0;
    defect[DEF_LOS]   = rx_los_i;
    defect[DEF_LOF]   = rx_lof_i;
    defect[DEF_AIS]   = rx_ais_i;
    defect[DEF_LOMF]  = rx_cas_lomf_i;
    defect[DEF_SIG1]  = rx_sig_ones_i;
    defect[DEF_CORR]  = rx_sig_corrupt_i;
    for (int i = 0; i < NUM_DEF; i++) begin
      nxt_alarm[i] = alarm_ff[i];
      nxt_cnt[i]   = '0;
      if (defect[i] != alarm_ff[i]) begin
        if (cnt_ff[i] == (alarm_ff[i] ? DEINTEG_LAST : INTEG_LAST)) begin
          nxt_alarm[i] = defect[i];
        end else begin
          nxt_cnt[i] = cnt_ff[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_ff <= '0;
      for (int i = 0; i < NUM_DEF; i++) begin
        cnt_ff[i] <= '0;
      end
    end else if (ce_i) begin
      alarm_ff <= nxt_alarm;
      for (int i = 0; i < NUM_DEF; i++) begin
        cnt_ff[i] <= nxt_cnt[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm decisions
  logic [CTL_W-1:0] ctl_ff;
  logic             red_ff;
  logic             nxt_red;
  logic             yreq_ff;
  logic             nxt_yreq;
  logic             creq_ff;
  logic             nxt_creq;

  always_comb begin
    nxt_red  = alarm_ff[DEF_LOS] | (alarm_ff[DEF_LOF] & ctl_ff[CTL_LOF_EN]);
    nxt_yreq = red_ff | alarm_ff[DEF_AIS];
    nxt_creq = alarm_ff[DEF_LOMF] | alarm_ff[DEF_SIG1] | alarm_ff[DEF_CORR];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      red_ff  <= 1'b0;
      yreq_ff <= 1'b0;
      creq_ff <= 1'b0;
    end else if (ce_i) begin
      red_ff  <= nxt_red;
      yreq_ff <= nxt_yreq;
      creq_ff <= nxt_creq;
    end
  end

  assign red_alarm_o = red_ff;
  ////////////////////////////////////////////////////////////////////////
  // Transmit frame position, pattern latching and bit insertion
  logic [2:0] bit_ff;
  logic [4:0] slot_ff;
  logic [3:0] frame_ff;
  ais_sel_t   ais_mode_ff;
  logic       yel_cur_ff;
  logic       casy_cur_ff;
  logic       tx_line_ff;
  logic       tx_vld_ff;
  logic [2:0] nxt_bit;
  logic [4:0] nxt_slot;
  logic [3:0] nxt_frame;
  ais_sel_t   nxt_ais_mode;
  logic       nxt_yel_cur;
  logic       nxt_casy_cur;
  logic       nxt_tx_line;
  logic [2:0] pos_bit;
  logic [4:0] pos_slot;
  logic [3:0] pos_frame;
  logic       frame_end;
  ais_sel_t   ais_req;
  logic       yel_val;
  logic       casy_val;
  logic       out_bit;

  always_comb begin
    pos_bit   = tx_sync_i ? '0 : bit_ff;
    pos_slot  = tx_sync_i ? '0 : slot_ff;
    pos_frame = tx_sync_i ? '0 : frame_ff;
    frame_end = (pos_bit == BIT_LAST) && (pos_slot == SLOT_LAST);
    ais_req   = ais_sel_t'(ctl_ff[CTL_AIS_LSB +: 2]);
    if (ais_req == AIS_NONE && ctl_ff[CTL_AUTO_AIS]) begin
      if (red_ff) begin
        ais_req = AIS_UNFRAMED;
      end else if (alarm_ff[DEF_CORR]) begin
        ais_req = AIS_SIG_SLOT;
      end
    end
    case (yel_sel_t'(ctl_ff[CTL_YEL_LSB +: 2]))
      YEL_AUTO: yel_val = yreq_ff;
      YEL_ONE:  yel_val = 1'b1;
      default:  yel_val = 1'b0;
    endcase
    case (yel_sel_t'(ctl_ff[CTL_CASY_LSB +: 2]))
      YEL_AUTO: casy_val = creq_ff;
      YEL_ONE:  casy_val = 1'b1;
      default:  casy_val = 1'b0;
    endcase
    out_bit = tx_bit_i;
    if (pos_slot == SLOT_FAS && pos_frame[0] && pos_bit == YEL_BIT_IDX) begin
      out_bit = yel_cur_ff;
    end
    if (pos_frame == MF_FRAME0 && pos_slot == SLOT_SIG && pos_bit == CASY_BIT_IDX) begin
      out_bit = casy_cur_ff;
    end
    case (ais_mode_ff)
      AIS_UNFRAMED: out_bit = 1'b1;
      AIS_FRAMED: begin
        if (pos_slot != SLOT_FAS) begin
          out_bit = 1'b1;
        end
      end
      AIS_SIG_SLOT: begin
        if (pos_slot == SLOT_SIG) begin
          out_bit = 1'b1;
        end
      end
      default: ;
    endcase
    nxt_bit      = bit_ff;
    nxt_slot     = slot_ff;
    nxt_frame    = frame_ff;
    nxt_ais_mode = ais_mode_ff;
    nxt_yel_cur  = yel_cur_ff;
    nxt_casy_cur = casy_cur_ff;
    nxt_tx_line  = tx_line_ff;
    if (tx_stb_i) begin
      nxt_tx_line = out_bit;
      nxt_bit     = pos_bit + 1'b1;
      nxt_slot    = (pos_bit == BIT_LAST) ? pos_slot + 1'b1 : pos_slot;
      nxt_frame   = frame_end ? pos_frame + 1'b1 : pos_frame;
      if (frame_end) begin
        nxt_ais_mode = ais_req;
        nxt_yel_cur  = yel_val;
        nxt_casy_cur = casy_val;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_ff      <= '0;
      slot_ff     <= '0;
      frame_ff    <= '0;
      ais_mode_ff <= AIS_NONE;
      yel_cur_ff  <= 1'b0;
      casy_cur_ff <= 1'b0;
      tx_line_ff  <= 1'b0;
      tx_vld_ff   <= 1'b0;
    end else if (ce_i) begin
      bit_ff      <= nxt_bit;
      slot_ff     <= nxt_slot;
      frame_ff    <= nxt_frame;
      ais_mode_ff <= nxt_ais_mode;
      yel_cur_ff  <= nxt_yel_cur;
      casy_cur_ff <= nxt_casy_cur;
      tx_line_ff  <= nxt_tx_line;
      tx_vld_ff   <= tx_stb_i;
    end
  end

  assign tx_line_o = tx_line_ff;
  assign tx_vld_o  = tx_vld_ff;
  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave, sticky status and interrupt
  logic             bus_req;
  logic             wr_lane0;
  logic [ST_W-1:0]  status_ff;
  logic [ST_W-1:0]  mask_ff;
  logic             ack_ff;
  logic             irq_ff;
  logic [DAT_W-1:0] dat_ff;
  logic [CTL_W-1:0] nxt_ctl;
  logic [ST_W-1:0]  nxt_status;
  logic [ST_W-1:0]  nxt_mask;
  logic [ST_W-1:0]  events;
  logic [ST_W-1:0]  w1c;
  logic [DAT_W-1:0] nxt_dat;

  always_comb begin
    bus_req  = wb_cyc_i && wb_stb_i && !ack_ff;
    wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
    events          = '0;
    events[ST_RED]  = red_ff ^ nxt_red;
    events[ST_AIS]  = alarm_ff[DEF_AIS] ^ nxt_alarm[DEF_AIS];
    events[ST_CASY] = creq_ff ^ nxt_creq;
    events[ST_BPV]  = rx_bpv_i;
    events[ST_BERR] = rx_bit_err_i;
    w1c      = (wr_lane0 && reg_hit(wb_adr_i, STAT_OFS)) ? wb_dat_i[ST_W-1:0] : '0;
    // A new event wins over a clear in the same cycle
    nxt_status = (status_ff & ~w1c) | events;
    nxt_ctl    = (wr_lane0 && reg_hit(wb_adr_i, CTL_OFS)) ? wb_dat_i[CTL_W-1:0] : ctl_ff;
    nxt_mask   = (wr_lane0 && reg_hit(wb_adr_i, MASK_OFS)) ? wb_dat_i[ST_W-1:0] : mask_ff;
    nxt_dat    = '0;
    if (bus_req && !wb_we_i) begin
      if (reg_hit(wb_adr_i, CTL_OFS)) begin
        nxt_dat = DAT_W'(ctl_ff);
      end else if (reg_hit(wb_adr_i, STAT_OFS)) begin
        nxt_dat = DAT_W'(status_ff);
      end else if (reg_hit(wb_adr_i, MASK_OFS)) begin
        nxt_dat = DAT_W'(mask_ff);
      end else if (reg_hit(wb_adr_i, STATE_OFS)) begin
        nxt_dat = DAT_W'({casy_cur_ff, yel_cur_ff, ais_mode_ff, red_ff, alarm_ff});
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_ff    <= CTL_RST;
      status_ff <= '0;
      mask_ff   <= MASK_RST;
      ack_ff    <= 1'b0;
      irq_ff    <= 1'b0;
      dat_ff    <= '0;
    end else if (ce_i) begin
      ctl_ff    <= nxt_ctl;
      status_ff <= nxt_status;
      mask_ff   <= nxt_mask;
      ack_ff    <= bus_req;
      irq_ff    <= |(status_ff & mask_ff);
      dat_ff    <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign irq_o    = irq_ff;
  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_RED_DECL: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (alarm_ff[DEF_LOS] || (alarm_ff[DEF_LOF] && ctl_ff[CTL_LOF_EN])) |=> red_alarm_o)
    else $error("Red alarm not declared on loss of signal or frame");
  AST_RED_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && status_ff[ST_RED] && mask_ff[ST_RED] |=> irq_o)
    else $error("Unmasked red alarm status did not raise the interrupt");
  AST_YELLOW_SENT: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tx_stb_i && yel_cur_ff && ais_mode_ff != AIS_UNFRAMED && pos_slot == SLOT_FAS &&
    pos_frame[0] && pos_bit == YEL_BIT_IDX |=> tx_line_o && tx_vld_o)
    else $error("Yellow bit not sent in non-alignment frame");
  AST_AUTO_AIS: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tx_stb_i && frame_end && red_ff && ctl_ff[CTL_AUTO_AIS] &&
    ctl_ff[CTL_AIS_LSB +: 2] == AIS_NONE |=> ais_mode_ff == AIS_UNFRAMED)
    else $error("AIS not started on lost incoming signal");
  AST_AIS_TO_YELLOW: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && alarm_ff[DEF_AIS] |=> yreq_ff)
    else $error("Received AIS did not request yellow alarm");
  AST_SIG_ONES: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tx_stb_i && ais_mode_ff == AIS_SIG_SLOT && pos_slot == SLOT_SIG |=> tx_line_o)
    else $error("Signaling slot not all ones");
  AST_CASY_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (alarm_ff[DEF_LOMF] || alarm_ff[DEF_SIG1] || alarm_ff[DEF_CORR]) |=> creq_ff)
    else $error("Multiframe yellow not requested");
  AST_CASY_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tx_stb_i && ais_mode_ff == AIS_NONE && pos_frame == MF_FRAME0 &&
    pos_slot == SLOT_SIG && pos_bit == CASY_BIT_IDX |=> tx_line_o == $past(casy_cur_ff))
    else $error("Multiframe yellow bit misplaced");
  AST_INTEG: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !alarm_ff[DEF_LOS] && cnt_ff[DEF_LOS] != INTEG_LAST |=> !alarm_ff[DEF_LOS])
    else $error("Loss of signal alarm declared before integration time");
  AST_UNFRAMED: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tx_stb_i && ais_mode_ff == AIS_UNFRAMED |=> tx_line_o)
    else $error("Unframed AIS sent a zero");
  AST_FRAMED: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tx_stb_i && ais_mode_ff == AIS_FRAMED |=>
    tx_line_o == ($past(pos_slot) != SLOT_FAS || $past(out_bit)))
    else $error("Framed AIS payload not all ones");
  AST_SEL_AT_BOUNDARY: assert property (@(posedge clk_i) disable iff (rst_i)
    !(ce_i && tx_stb_i && frame_end) |=> $stable(ais_mode_ff))
    else $error("AIS mode changed inside a frame");
  AST_WB_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 (!wb_ack_o || !ce_i))
    else $error("Bus acknowledge not single cycle");
endmodule // e1_alarm_gen
`default_nettype wire

/* File: e1_alarm_pkg.sv */
/*
  Constants for the E1 alarm and AIS generator: register map, field
  positions, reset values, mode encodings and E1 frame geometry.
  Assumes one channel, a 32-bit classic Wishbone slave and byte addresses.
*/
`default_nettype none
package e1_alarm_pkg;
  ////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int          ADR_W     = 12;
  localparam int          DAT_W     = 32;
  localparam int          SEL_W     = 4;
  localparam logic [11:0] CTL_OFS   = 12'h108;
  localparam logic [11:0] STAT_OFS  = 12'h10C;
  localparam logic [11:0] MASK_OFS  = 12'h110;
  localparam logic [11:0] STATE_OFS = 12'h114;
  localparam int          CTL_W     = 8;
  localparam logic [7:0]  CTL_RST   = 8'hD1;
  localparam logic [4:0]  MASK_RST  = 5'h01;
  // Alarm generation control fields
  localparam int CTL_YEL_LSB  = 0;
  localparam int CTL_AIS_LSB  = 2;
  localparam int CTL_CASY_LSB = 4;
  localparam int CTL_LOF_EN   = 6;
  localparam int CTL_AUTO_AIS = 7;
  // Sticky status and mask bits
  localparam int ST_RED  = 0;
  localparam int ST_AIS  = 1;
  localparam int ST_CASY = 2;
  localparam int ST_BPV  = 3;
  localparam int ST_BERR = 4;
  localparam int ST_W    = 5;
  // Received defects
  localparam int DEF_LOS   = 0;
  localparam int DEF_LOF   = 1;
  localparam int DEF_AIS   = 2;
  localparam int DEF_LOMF  = 3;
  localparam int DEF_SIG1  = 4;
  localparam int DEF_CORR  = 5;
  localparam int NUM_DEF   = 6;
  ////////////////////////////////////////////////////////////////////////
  // E1 frame geometry, first transmitted bit of a slot is index 0
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [4:0] SLOT_LAST    = 5'h1F;
  localparam logic [4:0] SLOT_FAS     = 5'h00;
  localparam logic [4:0] SLOT_SIG     = 5'h10;
  localparam logic [3:0] MF_FRAME0    = 4'h0;
  localparam logic [2:0] YEL_BIT_IDX  = 3'h1;
  localparam logic [2:0] CASY_BIT_IDX = 3'h5;
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    AIS_NONE     = 2'h0,
    AIS_UNFRAMED = 2'h1,
    AIS_SIG_SLOT = 2'h2,
    AIS_FRAMED   = 2'h3
  } ais_sel_t;
  typedef enum logic [1:0] {
    YEL_OFF  = 2'h0,
    YEL_AUTO = 2'h1,
    YEL_ZERO = 2'h2,
    YEL_ONE  = 2'h3
  } yel_sel_t;
endpackage
`default_nettype wire

/* File: e1_line_far.sv */
/*
  Far-end model: a framer bit source feeding the transmit path, and a
  line receiver that stores the last multiframe of transmitted bits.
  Assumes the block answers each bit strobe with tx_vld one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module e1_line_far (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        tx_line_i,
  input  wire logic        tx_vld_i,
  output logic             tx_stb_o,
  output logic             tx_sync_o,
  output logic             tx_bit_o,
  output logic [15:0]      mf_done_o
);
  // Position: [11:8] frame, [7:3] slot, [2:0] bit index
  logic [11:0] pos_ff;
  logic [11:0] cap_pos_ff;
  logic        cap [0:4095];

  assign tx_sync_o = tx_stb_o && (pos_ff == 12'h000);
  // Non-constant framer pattern, so passed bits differ from forced ones
  assign tx_bit_o  = pos_ff[0] ^ pos_ff[3] ^ pos_ff[8];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_stb_o   <= 1'b0;
      pos_ff     <= 12'h000;
      cap_pos_ff <= 12'h000;
      mf_done_o  <= 16'h0000;
    end else begin
      tx_stb_o <= 1'b1;
      if (tx_stb_o) begin
        pos_ff     <= pos_ff + 12'h001;
        cap_pos_ff <= pos_ff;
      end
      if (tx_vld_i) begin
        cap[cap_pos_ff] <= tx_line_i;
        if (cap_pos_ff == 12'hFFF) begin
          mf_done_o <= mf_done_o + 16'h0001;
        end
      end
    end
  end
endmodule // e1_line_far
`default_nettype wire

/* File: e1_alarm_and_ais_generation_test.sv */
/*
  Self-checking bench for the E1 alarm and AIS generator.
  Assumes e1_line_far as bit source and line receiver, and shortened
  integration counts of four cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module e1_alarm_and_ais_generation_test;
  import e1_alarm_pkg::*;
  logic             clk, rst, cyc, stb, we, ack, red, irq;
  logic             tx_stb, tx_sync, tx_bit, tx_line, tx_vld;
  logic [ADR_W-1:0] adr;
  logic [DAT_W-1:0] wdat, rdat;
  logic [SEL_W-1:0] sel;
  logic [7:0]       rx;
  logic [15:0]      mf_done;
  int               n_fail, num_checks;

  e1_alarm_gen #(.INTEG_CYCLES(4), .DEINTEG_CYCLES(4), .CNT_W(16)) uut (
    .clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_ack_o(ack), .wb_dat_o(rdat), .rx_los_i(rx[0]), .rx_lof_i(rx[1]),
    .rx_ais_i(rx[2]), .rx_cas_lomf_i(rx[3]), .rx_sig_ones_i(rx[4]),
    .rx_sig_corrupt_i(rx[5]), .rx_bpv_i(rx[6]), .rx_bit_err_i(rx[7]),
    .tx_stb_i(tx_stb), .tx_sync_i(tx_sync), .tx_bit_i(tx_bit),
    .tx_line_o(tx_line), .tx_vld_o(tx_vld), .red_alarm_o(red), .irq_o(irq));

  e1_line_far u_far (
    .clk_i(clk), .rst_i(rst), .tx_line_i(tx_line), .tx_vld_i(tx_vld),
    .tx_stb_o(tx_stb), .tx_sync_o(tx_sync), .tx_bit_o(tx_bit),
    .mf_done_o(mf_done));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %b", $time, msg, got);
    end
  endtask

  task automatic wb_xfer(input logic we_v, input logic [ADR_W-1:0] adr_v,
                         input logic [DAT_W-1:0] dat_v, output logic [DAT_W-1:0] rd_v);
    @(posedge clk);
    {cyc, stb, we} <= {2'b11, we_v};
    adr <= adr_v;
    wdat <= dat_v;
    do @(posedge clk); while (ack !== 1'b1);
    rd_v = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask

  task automatic wb_wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    logic [DAT_W-1:0] unused;
    wb_xfer(1'b1, a, d, unused);
  endtask

  task automatic wb_rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] exp, input string msg);
    logic [DAT_W-1:0] got;
    wb_xfer(1'b0, a, 32'h0, got);
    chk(got, exp, msg);
  endtask

  // Expected line bit for a multiframe position
  function automatic logic exp_bit(input logic [11:0] p, input logic [1:0] ais,
                                   input logic y, input logic m);
    logic b;
    b = p[0] ^ p[3] ^ p[8];
    if (p[7:3] == SLOT_FAS && p[8] && p[2:0] == YEL_BIT_IDX) b = y;
    if (p[11:8] == MF_FRAME0 && p[7:3] == SLOT_SIG && p[2:0] == CASY_BIT_IDX) b = m;
    if (ais == 2'h1 || (ais == 2'h3 && p[7:3] != SLOT_FAS)) b = 1'b1;
    if (ais == 2'h2 && p[7:3] == SLOT_SIG) b = 1'b1;
    return b;
  endfunction

  // Skips the multiframe in progress, then compares one whole multiframe
  task automatic chk_line(input logic [1:0] ais, input logic y, input logic m);
    int bad, tgt;
    bad = 0;
    tgt = int'(mf_done) + 2;
    while (int'(mf_done) < tgt) @(posedge clk);
    for (int i = 0; i < 4096; i++) begin
      if (u_far.cap[i] !== exp_bit(i[11:0], ais, y, m)) bad++;
    end
    chk(32'(bad), 32'h0, "line bits");
  endtask

  task automatic final_report();
    $display("Checks made: %0d, mismatches: %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #(90000 * 100);
    n_fail++;
    $display("CHECK FAILED at %0t: timeout", $time);
    final_report();
  end

  initial begin
    n_fail = 0;
    num_checks = 0;
    rst <= 1'b1;
    {cyc, stb, we} <= 3'b000;
    adr <= '0;
    wdat <= '0;
    sel <= 4'hF;
    rx <= 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wb_rd(CTL_OFS, {24'h0, CTL_RST}, "control reset");
    wb_rd(MASK_OFS, {27'h0, MASK_RST}, "mask reset");
    wb_rd(STAT_OFS, 32'h0, "status reset");
    wb_wr(12'h200, 32'hFFFF_FFFF);
    wb_rd(12'h200, 32'h0, "unmapped");
    // Every AIS code, yellow forced one, multiframe yellow forced zero
    for (int c = 0; c < 4; c++) begin
      wb_wr(CTL_OFS, 32'hFFFF_FF63 | 32'(c << 2));
      wb_rd(CTL_OFS, 32'h63 | 32'(c << 2), "control field");
      chk_line(c[1:0], 1'b1, 1'b0);
    end
    // Line errors only reach sticky status
    wb_wr(CTL_OFS, {24'h0, CTL_RST});
    rx <= 8'hC0;
    repeat (10) @(posedge clk);
    rx <= 8'h00;
    repeat (2) @(posedge clk);
    chk_bit(red, 1'b0, "red on errors");
    chk_bit(irq, 1'b0, "masked irq");
    wb_rd(STAT_OFS, 32'h18, "error status");
    wb_wr(MASK_OFS, 32'h18);
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b1, "error irq");
    wb_wr(STAT_OFS, 32'h18);
    wb_wr(MASK_OFS, 32'h01);
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b0, "irq cleared");
    // Loss of frame: glitch, then held
    rx <= 8'h02;
    repeat (3) @(posedge clk);
    rx <= 8'h00;
    repeat (8) @(posedge clk);
    chk_bit(red, 1'b0, "red on glitch");
    rx <= 8'h02;
    repeat (3) @(posedge clk);
    chk_bit(red, 1'b0, "red early");
    repeat (5) @(posedge clk);
    chk_bit(red, 1'b1, "red declared");
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b1, "red irq");
    wb_rd(STAT_OFS, 32'h1, "red status");
    chk_line(2'h1, 1'b1, 1'b0);
    wb_wr(CTL_OFS, 32'h51);
    chk_line(2'h0, 1'b1, 1'b0);
    rx <= 8'h00;
    repeat (3) @(posedge clk);
    chk_bit(red, 1'b1, "red held");
    repeat (6) @(posedge clk);
    chk_bit(red, 1'b0, "red cleared");
    wb_wr(STAT_OFS, 32'h1F);
    // Received AIS, lost multiframe, corrupt signaling slot
    wb_wr(CTL_OFS, 32'h41);
    rx <= 8'h04;
    chk_line(2'h0, 1'b1, 1'b0);
    wb_wr(CTL_OFS, 32'h51);
    rx <= 8'h08;
    chk_line(2'h0, 1'b0, 1'b1);
    wb_wr(CTL_OFS, {24'h0, CTL_RST});
    rx <= 8'h20;
    chk_line(2'h2, 1'b0, 1'b1);
    final_report();
  end
endmodule // e1_alarm_and_ais_generation_test
`default_nettype wire
